// [pbcet_defines.svh]
`ifndef PBCET_DEFINES_SVH
`define PBCET_DEFINES_SVH
// ==========================================================================
// Register byte offsets on the Avalon-MM slave
`define PBCET_OFS_CAP_CTRL 6'h00
`define PBCET_OFS_CAP_VALUE 6'h04
`define PBCET_OFS_OFF_SET 6'h08
`define PBCET_OFS_OFF_CNT 6'h0C
`define PBCET_OFS_WIN_SET 6'h10
`define PBCET_OFS_WIN_CNT 6'h14
`define PBCET_OFS_TRIG_SEL 6'h18
`define PBCET_OFS_TRIG_PRE 6'h1C
`define PBCET_OFS_FLAGS 6'h20
`define PBCET_OFS_FLAG_CLR 6'h24
`define PBCET_OFS_REF_SEL 6'h28
// ==========================================================================
// Field positions
`define PBCET_CAP_EN_BIT 0
`define PBCET_CAP_SHADOW_BIT 1
`define PBCET_SEL_B_EN_BIT 15
`define PBCET_SEL_B_LSB 12
`define PBCET_SEL_A_EN_BIT 11
`define PBCET_SEL_A_LSB 8
`define PBCET_SEL_I_EN_BIT 3
`define PBCET_SEL_I_LSB 0
`define PBCET_PRE_B_LSB 12
`define PBCET_PRE_A_LSB 8
`define PBCET_PRE_I_LSB 0
`define PBCET_FLAG_B_BIT 3
`define PBCET_FLAG_A_BIT 2
`define PBCET_FLAG_I_BIT 0
// ==========================================================================
// Reset values and write masks
`define PBCET_RST_16 16'h0000
`define PBCET_RST_8 8'h00
`define PBCET_TRIG_SEL_MASK 16'hFF0F
`define PBCET_TRIG_PRE_MASK 16'h3303
`endif

// [pbcet_pkg.sv]
// ==========================================================================
// Shared types of the blanking, capture and event-trigger block
package pbcet_pkg;
	// Channel numbering of the three prescaled event outputs
	typedef enum logic [1:0] {
		PBCET_CH_START_A,
		PBCET_CH_START_B,
		PBCET_CH_IRQ
	} pbcet_chan_e;
	// Reference point choice for blanking and capture
	typedef enum logic [1:0] {
		PBCET_REF_PERIOD,
		PBCET_REF_ZERO,
		PBCET_REF_RSVD2,
		PBCET_REF_RSVD3
	} pbcet_ref_e;
	// Event selector code
	typedef logic [2:0] pbcet_evsel_t;
endpackage : pbcet_pkg

// [pbcet_prescaler.sv]
`timescale 1ns/1ps
// ==========================================================================
// Event prescaler: counts selected events and emits one pulse per N events
module pbcet_prescaler
	import pbcet_pkg::*;
#(
	parameter int CNT_W = 2,
	parameter bit IRQ_MODE = 1'b0
) (
	input wire logic clk,
	input wire logic arst_n,
	input wire logic tick,
	input wire logic event_hit,
	input wire logic enable,
	input wire logic [CNT_W-1:0] prescale,
	input wire logic flag,
	output logic [CNT_W-1:0] count,
	output logic pulse
);
	// ==========================================================================
	// Elaboration check
	if (CNT_W < 1) begin : g_bad_width
		$error("pbcet_prescaler: CNT_W must be at least 1");
	end

	// ==========================================================================
	// State
	typedef struct packed {
		logic [CNT_W-1:0] cnt; // Events seen since last pulse
		logic pls; // Registered output pulse
	} pbcet_psc_s;

	pbcet_psc_s s; // Current state
	pbcet_psc_s next_s; // Next state

	// Counting and pulse decision, evaluated on time-base ticks only
	always_comb begin
		logic [CNT_W-1:0] bumped;
		logic blocked;
		bumped = s.cnt;
		blocked = 1'b0;
		next_s = s;
		next_s.pls = 1'b0;
		// Interrupt channel holds back while its flag is still set
		blocked = IRQ_MODE && flag;
		if (tick) begin
			if (prescale == '0) begin
				// Prescale zero disables counter and pulses
				next_s.cnt = '0;
			end else begin
				// Saturate at prescale so a held-off count stays pending
				if (event_hit && (s.cnt != prescale)) begin
					bumped = s.cnt + CNT_W'(1);
				end
				if (enable && !blocked && (bumped == prescale)) begin
					// Pulse on the Nth event even with flag set (SOC)
					next_s.pls = 1'b1;
					next_s.cnt = '0; // Auto-clear after each pulse
				end else begin
					next_s.cnt = bumped;
				end
			end
		end
	end

	// State register
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			s <= '0;
		end else begin
			s <= next_s;
		end
	end

	assign count = s.cnt; // Read-only event count
	assign pulse = s.pls;
endmodule : pbcet_prescaler

// [pbcet_top.sv]
// The register offsets and the Avalon-MM interface to the registers were left to the implementer.
`timescale 1ns/1ps
`include "pbcet_defines.svh"
module pbcet_top
	import pbcet_pkg::*;
#(
	parameter int CAP_W = 16,
	parameter int WIN_W = 8
) (
	input wire logic clk,
	input wire logic arst_n,
	// Avalon-MM slave
	input wire logic [5:0] address,
	input wire logic read,
	input wire logic write,
	input wire logic [31:0] writedata,
	input wire logic [3:0] byteenable,
	output logic [31:0] readdata,
	output logic waitrequest,
	// Time base side
	input wire logic timebase_tick,
	input wire logic [CAP_W-1:0] timebase_counter,
	input wire logic ctr_zero,
	input wire logic ctr_period,
	input wire logic compare_value_a_up,
	input wire logic compare_value_a_down,
	input wire logic compare_value_b_up,
	input wire logic compare_value_b_down,
	input wire logic compare_a_event1_start,
	input wire logic compare_b_event1_start,
	input wire logic filtered_compare_event,
	// Outputs
	output logic blank_window_active,
	output logic converter_start_a_pulse,
	output logic converter_start_b_pulse,
	output logic pwm_irq_pulse
);
	// ==========================================================================
	// Elaboration checks
	if (CAP_W != 16) begin : g_bad_cap
		$error("pbcet_top: CAP_W must be 16 to fit the register map");
	end
	if ((WIN_W < 1) || (WIN_W > 16)) begin : g_bad_win
		$error("pbcet_top: WIN_W must be 1 to 16");
	end

	// ==========================================================================
	// State of the block
	typedef struct packed {
		logic ack; // Second cycle of a bus access
		logic [31:0] rdata; // Registered read data
		logic cap_shadow_sel; // 1 bypasses shadow copy
		logic cap_en; // Capture enable
		logic [1:0] ref_sel; // Reference pulse select
		logic [15:0] cap_active; // Active capture value
		logic [15:0] cap_shadow; // Shadow capture value
		logic cap_done; // Capture taken this interval
		logic evt_prev; // Filtered event at previous tick
		logic [15:0] off_set; // Offset setting (shadow side)
		logic [15:0] off_cnt; // Offset down counter
		logic [WIN_W-1:0] win_set; // Window width setting
		logic [WIN_W-1:0] win_cnt; // Window down counter
		logic [15:0] tsel; // Trigger select register
		logic [15:0] tpre; // Prescale fields only
		logic [2:0] flags; // {start b, start a, irq} latched flags
	} pbcet_state_s;

	pbcet_state_s s; // Current state
	pbcet_state_s next_s; // Next state

	// ==========================================================================
	// Prescaler channel wiring
	logic [2:0] ch_hit; // Selected event per channel
	logic [2:0] ch_en; // Channel enable
	logic [2:0] ch_flag; // Latched flag per channel
	logic [1:0] ch_pre [3]; // Prescale per channel
	logic [1:0] ch_cnt [3]; // Event count per channel
	logic [2:0] ch_pulse; // Pulse per channel
	logic ref_hit; // Reference point at this tick
	logic bus_req; // Any access pending
	logic wr_go; // Write takes effect this edge

	// Decode a selector code to its time-base event
	function automatic logic ev_decode(input pbcet_evsel_t code, input logic dc_evt);
		logic hit;
		hit = 1'b0;
		unique case (code)
			3'h0: hit = dc_evt; // Compare event-1 start, none for irq
			3'h1: hit = ctr_zero;
			3'h2: hit = ctr_period;
			3'h3: hit = ctr_zero | ctr_period;
			3'h4: hit = compare_value_a_up;
			3'h5: hit = compare_value_a_down;
			3'h6: hit = compare_value_b_up;
			3'h7: hit = compare_value_b_down;
		endcase
		return hit;
	endfunction : ev_decode

	// Merge byte lanes of a write into a 16-bit register
	function automatic logic [15:0] lane16(input logic [15:0] old, input logic [31:0] wd,
		input logic [3:0] be);
		logic [15:0] res;
		res = old;
		if (be[0]) begin
			res[7:0] = wd[7:0];
		end
		if (be[1]) begin
			res[15:8] = wd[15:8];
		end
		return res;
	endfunction : lane16

	// Event selection for the three channels
	always_comb begin
		// Start A code 000 picks compare A event-1 start
		ch_hit[PBCET_CH_START_A] = ev_decode(s.tsel[`PBCET_SEL_A_LSB +: 3],
			compare_a_event1_start);
		// Start B code 000 picks compare B event-1 start
		ch_hit[PBCET_CH_START_B] = ev_decode(s.tsel[`PBCET_SEL_B_LSB +: 3],
			compare_b_event1_start);
		// Interrupt code 000 is reserved and selects nothing
		ch_hit[PBCET_CH_IRQ] = ev_decode(s.tsel[`PBCET_SEL_I_LSB +: 3], 1'b0);
		ch_en[PBCET_CH_START_A] = s.tsel[`PBCET_SEL_A_EN_BIT];
		ch_en[PBCET_CH_START_B] = s.tsel[`PBCET_SEL_B_EN_BIT];
		ch_en[PBCET_CH_IRQ] = s.tsel[`PBCET_SEL_I_EN_BIT];
		ch_flag[PBCET_CH_START_A] = s.flags[1];
		ch_flag[PBCET_CH_START_B] = s.flags[2];
		// A pulse still in flight counts as a set flag, so back-to-back ticks hold off
		ch_flag[PBCET_CH_IRQ] = s.flags[0] | ch_pulse[PBCET_CH_IRQ];
		ch_pre[PBCET_CH_START_A] = s.tpre[`PBCET_PRE_A_LSB +: 2];
		ch_pre[PBCET_CH_START_B] = s.tpre[`PBCET_PRE_B_LSB +: 2];
		ch_pre[PBCET_CH_IRQ] = s.tpre[`PBCET_PRE_I_LSB +: 2];
	end

	// ==========================================================================
	// One prescaler per channel; only the interrupt channel honours its flag
	for (genvar g = 0; g < 3; g++) begin : g_chan
		pbcet_prescaler #(
			.CNT_W(2),
			.IRQ_MODE(g == int'(PBCET_CH_IRQ))
		) u_psc (
			.clk(clk),
			.arst_n(arst_n),
			.tick(timebase_tick),
			.event_hit(ch_hit[g]),
			.enable(ch_en[g]),
			.prescale(ch_pre[g]),
			.flag(ch_flag[g]),
			.count(ch_cnt[g]),
			.pulse(ch_pulse[g])
		);
	end

	// Reference point; reserved select codes give no reference
	always_comb begin
		unique case (pbcet_ref_e'(s.ref_sel))
			PBCET_REF_PERIOD: ref_hit = ctr_period;
			PBCET_REF_ZERO: ref_hit = ctr_zero;
			PBCET_REF_RSVD2: ref_hit = 1'b0;
			PBCET_REF_RSVD3: ref_hit = 1'b0;
		endcase
	end

	// Bus handshake: every access waits exactly one cycle
	assign bus_req = read | write;
	assign wr_go = write & s.ack;

	// ==========================================================================
	// Main next-state logic
	always_comb begin
		logic off_expire;
		logic [31:0] rd;
		off_expire = 1'b0;
		rd = 32'h0000_0000;
		next_s = s;

		// Bus acknowledge toggles for one cycle per access
		next_s.ack = bus_req & ~s.ack;

		// Read mux, registered on the first cycle of a read
		unique case (address)
			`PBCET_OFS_CAP_CTRL: rd[1:0] = {s.cap_shadow_sel, s.cap_en};
			// One address, mode picks shadow or active
			`PBCET_OFS_CAP_VALUE: rd[15:0] = s.cap_shadow_sel ? s.cap_active : s.cap_shadow;
			`PBCET_OFS_OFF_SET: rd[15:0] = s.off_set;
			`PBCET_OFS_OFF_CNT: rd[15:0] = s.off_cnt;
			`PBCET_OFS_WIN_SET: rd[WIN_W-1:0] = s.win_set;
			`PBCET_OFS_WIN_CNT: rd[WIN_W-1:0] = s.win_cnt;
			`PBCET_OFS_TRIG_SEL: rd[15:0] = s.tsel;
			// Counts are read-only beside the prescale fields
			`PBCET_OFS_TRIG_PRE: rd[15:0] = s.tpre | {ch_cnt[PBCET_CH_START_B], 2'b00,
				ch_cnt[PBCET_CH_START_A], 6'h00, ch_cnt[PBCET_CH_IRQ], 2'b00};
			`PBCET_OFS_FLAGS: rd[3:0] = {s.flags[2:1], 1'b0, s.flags[0]};
			`PBCET_OFS_REF_SEL: rd[1:0] = s.ref_sel;
			default: rd = 32'h0000_0000; // Unmapped and clear register read zero
		endcase
		if (read && !s.ack) begin
			next_s.rdata = rd;
		end

		// Register writes on the edge where waitrequest is low
		if (wr_go) begin
			unique case (address)
				`PBCET_OFS_CAP_CTRL: begin
					if (byteenable[0]) begin
						next_s.cap_en = writedata[`PBCET_CAP_EN_BIT];
						next_s.cap_shadow_sel = writedata[`PBCET_CAP_SHADOW_BIT];
					end
				end
				`PBCET_OFS_OFF_SET: next_s.off_set = lane16(s.off_set, writedata, byteenable);
				`PBCET_OFS_WIN_SET: begin
					// Upper bits are reserved and ignored here
					if (byteenable[0]) begin
						next_s.win_set = writedata[WIN_W-1:0];
					end
				end
				`PBCET_OFS_TRIG_SEL: begin
					next_s.tsel = lane16(s.tsel, writedata, byteenable)
						& `PBCET_TRIG_SEL_MASK;
				end
				`PBCET_OFS_TRIG_PRE: begin
					next_s.tpre = lane16(s.tpre, writedata, byteenable)
						& `PBCET_TRIG_PRE_MASK;
				end
				`PBCET_OFS_REF_SEL: begin
					if (byteenable[0]) begin
						next_s.ref_sel = writedata[1:0];
					end
				end
				default: begin
					// Read-only, clear and unmapped words store nothing here
				end
			endcase
		end

		// Flag clear by writing ones; a pulse in the same cycle wins below
		if (wr_go && (address == `PBCET_OFS_FLAG_CLR) && byteenable[0]) begin
			if (writedata[`PBCET_FLAG_B_BIT]) begin
				next_s.flags[2] = 1'b0;
			end
			if (writedata[`PBCET_FLAG_A_BIT]) begin
				next_s.flags[1] = 1'b0;
			end
			if (writedata[`PBCET_FLAG_I_BIT]) begin
				next_s.flags[0] = 1'b0;
			end
		end
		// Latch flags from the pulses
		if (ch_pulse[PBCET_CH_START_B]) begin
			next_s.flags[2] = 1'b1;
		end
		if (ch_pulse[PBCET_CH_START_A]) begin
			next_s.flags[1] = 1'b1;
		end
		if (ch_pulse[PBCET_CH_IRQ]) begin
			next_s.flags[0] = 1'b1; // Blocks the next interrupt until cleared
		end

		// ==========================================================================
		// Time-base tick work: capture and blanking
		// No halt input exists; counting never stops for emulation
		if (timebase_tick) begin
			next_s.evt_prev = filtered_compare_event;
			if (ref_hit) begin
				// Shadow copy taken at the reference point
				if (!s.cap_shadow_sel) begin
					next_s.cap_shadow = s.cap_active;
				end
				next_s.cap_done = 1'b0; // Re-arm for the next capture
			end
			// Capture counter on rising edge, once per interval
			if (s.cap_en && filtered_compare_event && !s.evt_prev && !s.cap_done) begin
				next_s.cap_active = timebase_counter;
				next_s.cap_done = 1'b1;
			end

			// Offset counter: load at reference, then count down
			if (ref_hit) begin
				next_s.off_cnt = s.off_set;
				off_expire = (s.off_set == 16'h0000);
			end else if (s.off_cnt != 16'h0000) begin
				// Counts to zero then stops
				next_s.off_cnt = s.off_cnt - 16'h0001;
				off_expire = (s.off_cnt == 16'h0001);
			end

			// Window counter: load or restart on expiry
			if (off_expire) begin
				next_s.win_cnt = s.win_set;
			end else if (s.win_cnt != '0) begin
				// Runs on through period boundaries, holds at zero
				next_s.win_cnt = s.win_cnt - WIN_W'(1);
			end
		end
	end

	// ==========================================================================
	// State register
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			s <= '0;
		end else begin
			s <= next_s;
		end
	end

	// ==========================================================================
	// Outputs
	assign waitrequest = bus_req & ~s.ack;
	assign readdata = s.rdata;
	assign blank_window_active = (s.win_cnt != '0); // Zero width gives none
	assign converter_start_a_pulse = ch_pulse[PBCET_CH_START_A];
	assign converter_start_b_pulse = ch_pulse[PBCET_CH_START_B];
	assign pwm_irq_pulse = ch_pulse[PBCET_CH_IRQ];
endmodule : pbcet_top

// [pbcet_checker.sv]
`timescale 1ns/1ps
`include "pbcet_defines.svh"
// ==========================================================================
// Port checks of the blanking, capture and event-trigger block
module pbcet_checker #(
	parameter int CAP_W = 16,
	parameter int WIN_W = 8
) (
	input wire logic clk,
	input wire logic arst_n,
	input wire logic [5:0] address,
	input wire logic read,
	input wire logic write,
	input wire logic [31:0] readdata,
	input wire logic waitrequest,
	input wire logic timebase_tick,
	input wire logic ctr_zero,
	input wire logic ctr_period,
	input wire logic compare_value_a_up,
	input wire logic compare_value_a_down,
	input wire logic compare_value_b_up,
	input wire logic compare_value_b_down,
	input wire logic compare_a_event1_start,
	input wire logic compare_b_event1_start,
	input wire logic blank_window_active,
	input wire logic converter_start_a_pulse,
	input wire logic converter_start_b_pulse,
	input wire logic pwm_irq_pulse
);
	default clocking @(posedge clk); endclocking
	default disable iff (!arst_n);
	// Any counter event on the time base
	wire logic any_ev = ctr_zero | ctr_period | compare_value_a_up | compare_value_a_down | compare_value_b_up | compare_value_b_down;
	// ==========================================================================
	// Bus handshake steps
	sequence s_wait;
		(read || write) && waitrequest;
	endsequence
	// Answer cycle; the next cycle waits again only if a new request is already up
	sequence s_answer;
		!waitrequest ##1 (waitrequest == (read || write));
	endsequence
	chk_wait_once: assert property (s_wait |=> s_answer)
		else $error("bus access did not finish after one wait cycle");
	chk_wait_idle: assert property (!(read || write) |-> !waitrequest)
		else $error("wait raised with no access");
	chk_upper_zero: assert property (read && !waitrequest |-> readdata[31:16] == 16'h0000)
		else $error("upper read bits not zero");
	chk_widthcnt_upper: assert property (read && !waitrequest && address == `PBCET_OFS_WIN_CNT
		|-> readdata[31:8] == 24'h000000) else $error("width counter wider than eight bits");
	// ==========================================================================
	// Start pulses are checked against a tick that carried a usable event
	chk_start_a_cause: assert property (converter_start_a_pulse
		|-> $past(timebase_tick && (any_ev || compare_a_event1_start)))
		else $error("start A pulse without a tick event");
	chk_start_b_cause: assert property (converter_start_b_pulse
		|-> $past(timebase_tick && (any_ev || compare_b_event1_start)))
		else $error("start B pulse without a tick event");
	// A pending interrupt may fire on an event-free tick, so only the tick is tied
	chk_irq_tick: assert property (pwm_irq_pulse |-> $past(timebase_tick))
		else $error("interrupt pulse without a tick");
	// The pulse itself counts as a set flag, so the very next cycle cannot pulse
	chk_irq_single: assert property (pwm_irq_pulse |=> !pwm_irq_pulse)
		else $error("interrupt pulsed twice in a row");
	chk_window_tick: assert property ($changed(blank_window_active) |-> $past(timebase_tick))
		else $error("window moved without a tick");
endmodule : pbcet_checker

// [pbcet_sink.sv]
`timescale 1ns/1ps
// ==========================================================================
// Converter start inputs and interrupt controller: counts every pulse
module pbcet_sink (
	input wire logic clk,
	input wire logic arst_n,
	input wire logic start_a,
	input wire logic start_b,
	input wire logic irq,
	output int n_a,
	output int n_b,
	output int n_i
);
	// One count per high cycle, so a stretched pulse shows as extra counts
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			n_a <= 0;
			n_b <= 0;
			n_i <= 0;
		end else begin
			n_a <= n_a + int'(start_a);
			n_b <= n_b + int'(start_b);
			n_i <= n_i + int'(irq);
		end
	end
endmodule : pbcet_sink

// [tb.sv]
`timescale 1ns/1ps
`include "pbcet_defines.svh"
// ==========================================================================
// Self-checking bench
module tb
	import pbcet_pkg::*;
;
	logic clk = 1'b0, arst_n = 1'b0, read = 1'b0, write = 1'b0, tick = 1'b0, fce = 1'b0;
	logic [5:0] address = 6'h00;
	logic [31:0] writedata = 32'h00000000;
	logic [3:0] byteenable = 4'hF;
	logic [15:0] tbc = 16'h0000;
	logic [7:0] ev = 8'h00; // {compare_value_b dn, compare_value_b up, compare_value_a dn, compare_value_a up, period, zero, b1, a1}
	logic [31:0] readdata;
	logic waitrequest, win, pa, pb, pi;
	int n_a, n_b, n_i, failures = 0, num_checks = 0;
	logic [31:0] seed = 32'h00010B93; // Xorshift start value
	typedef struct {string nm; logic [31:0] v;} pbcet_exp_s;
	pbcet_exp_s exp_q[$]; // Read results still owed
	pbcet_top pbcet_top_i (.clk(clk), .arst_n(arst_n), .address(address), .read(read),
		.write(write), .writedata(writedata), .byteenable(byteenable), .readdata(readdata),
		.waitrequest(waitrequest), .timebase_tick(tick), .timebase_counter(tbc),
		.ctr_zero(ev[2]), .ctr_period(ev[3]), .compare_value_a_up(ev[4]), .compare_value_a_down(ev[5]),
		.compare_value_b_up(ev[6]), .compare_value_b_down(ev[7]), .compare_a_event1_start(ev[0]),
		.compare_b_event1_start(ev[1]), .filtered_compare_event(fce),
		.blank_window_active(win), .converter_start_a_pulse(pa),
		.converter_start_b_pulse(pb), .pwm_irq_pulse(pi));
	pbcet_sink pbcet_sink_i (.clk(clk), .arst_n(arst_n), .start_a(pa), .start_b(pb), .irq(pi),
		.n_a(n_a), .n_b(n_b), .n_i(n_i));
	// ==========================================================================
	// Helpers
	initial forever #5 clk = ~clk;
	function automatic logic [31:0] xs();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction : xs
	// Expected pulse for selector s, events e, channel b (0 A, 1 B)
	function automatic logic [31:0] hit(int s, logic [7:0] e, int b);
		return {31'h0, s == 0 ? e[b] : s == 3 ? (e[2] | e[3]) : s < 3 ? e[s + 1] : e[s]};
	endfunction : hit
	task automatic check(string nm, logic [31:0] seen, logic [31:0] want);
		num_checks++;
		if (seen !== want) begin
			failures++;
			$display("[ERR] %s expected %h seen %h", nm, want, seen);
		end
	endtask : check
	task automatic results();
		$display("checks %0d failures %0d", num_checks, failures);
		if (failures == 0 && num_checks > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask : results
	// Bus access: hold until the rising edge that samples waitrequest low, release there
	task automatic acc(logic w, logic [5:0] a, logic [15:0] d);
		@(posedge clk);
		address <= a;
		read <= !w;
		write <= w;
		writedata <= {16'h0000, d};
		do @(posedge clk); while (waitrequest);
		read <= 1'b0;
		write <= 1'b0;
	endtask : acc
	task automatic rd(logic [5:0] a, logic [15:0] v, string nm);
		exp_q.push_back('{nm, {16'h0000, v}});
		acc(1'b0, a, 16'h0000);
	endtask : rd
	// One tick with events e and filtered level f; waits until the sink has counted the pulse
	task automatic tk(logic [7:0] e, logic f);
		@(posedge clk);
		tick <= 1'b1;
		ev <= e;
		fce <= f;
		tbc <= 16'(xs());
		@(posedge clk);
		tick <= 1'b0;
		ev <= 8'h00;
		@(posedge clk);
		@(negedge clk);
	endtask : tk
	// Read monitor takes the oldest note at the answer edge
	always @(posedge clk) begin
		pbcet_exp_s e;
		if (read && !waitrequest) begin
			e = exp_q.pop_front();
			check(e.nm, readdata, e.v);
		end
	end
	// Hang guard
	initial begin
		repeat (20000) @(posedge clk);
		failures++;
		results();
	end
	// ==========================================================================
	// Main sequence
	initial begin
		logic [7:0] e;
		logic [15:0] c1, c3;
		int a0, b0, i0;
		repeat (16) @(posedge clk);
		arst_n <= 1'b1;
		for (int a = 0; a < 48; a += 4) rd(6'(a), 16'h0000, "reset or unmapped");
		acc(1'b1, `PBCET_OFS_OFF_CNT, 16'hFFFF);
		rd(`PBCET_OFS_OFF_CNT, 16'h0000, "offset counter read only");
		// Every selector code against random events
		acc(1'b1, `PBCET_OFS_TRIG_PRE, 16'h1101);
		for (int s = 0; s < 8; s++) begin
			acc(1'b1, `PBCET_OFS_TRIG_SEL, 16'h8808 | 16'(s << 12) | 16'(s << 8) | 16'(s));
			for (int k = 0; k < 4; k++) begin
				e = (k == 0) ? 8'hFF : 8'(xs());
				a0 = n_a;
				b0 = n_b;
				i0 = n_i;
				tk(e, 1'b0);
				check("start a", 32'(n_a - a0), hit(s, e, 0));
				check("start b", 32'(n_b - b0), hit(s, e, 1));
				check("irq", 32'(n_i - i0), s == 0 ? 32'h0 : hit(s, e, 0));
				acc(1'b1, `PBCET_OFS_FLAG_CLR, 16'h000D);
			end
		end
		// Prescale of three on zero events
		acc(1'b1, `PBCET_OFS_TRIG_SEL, 16'h9919);
		acc(1'b1, `PBCET_OFS_TRIG_PRE, 16'h3303);
		a0 = n_a;
		b0 = n_b;
		i0 = n_i;
		tk(8'h04, 1'b0);
		tk(8'h04, 1'b0);
		rd(`PBCET_OFS_TRIG_PRE, 16'hBB0B, "two events");
		tk(8'h04, 1'b0);
		check("third a", 32'(n_a - a0), 32'h1);
		check("third b", 32'(n_b - b0), 32'h1);
		rd(`PBCET_OFS_TRIG_PRE, 16'h3303, "auto clear");
		repeat (3) tk(8'h04, 1'b0);
		check("flag ignored", 32'(n_b - b0), 32'h2);
		check("irq held", 32'(n_i - i0), 32'h1);
		rd(`PBCET_OFS_TRIG_PRE, 16'h330F, "irq saturates");
		rd(`PBCET_OFS_FLAGS, 16'h000D, "flags latched");
		acc(1'b1, `PBCET_OFS_FLAG_CLR, 16'h0001);
		tk(8'h00, 1'b0);
		check("pending irq", 32'(n_i - i0), 32'h2);
		acc(1'b1, `PBCET_OFS_TRIG_PRE, 16'h0000);
		tk(8'h04, 1'b0);
		check("prescale off", 32'(n_a - a0), 32'h2);
		rd(`PBCET_OFS_TRIG_PRE, 16'h0000, "counts off");
		// Blanking: offset two, width three, zero reference
		acc(1'b1, `PBCET_OFS_REF_SEL, 16'h0001);
		acc(1'b1, `PBCET_OFS_OFF_SET, 16'h0002);
		acc(1'b1, `PBCET_OFS_WIN_SET, 16'h0003);
		tk(8'h04, 1'b0);
		rd(`PBCET_OFS_OFF_CNT, 16'h0002, "offset load");
		tk(8'h00, 1'b0);
		tk(8'h00, 1'b0);
		check("window open", {31'h0, win}, 32'h1);
		rd(`PBCET_OFS_WIN_CNT, 16'h0003, "width load");
		tk(8'h04, 1'b0);
		check("window crosses", {31'h0, win}, 32'h1);
		tk(8'h00, 1'b0);
		tk(8'h00, 1'b0);
		rd(`PBCET_OFS_WIN_CNT, 16'h0003, "width restart");
		repeat (3) tk(8'h00, 1'b0);
		check("window closed", {31'h0, win}, 32'h0);
		rd(`PBCET_OFS_OFF_CNT, 16'h0000, "offset hold");
		rd(`PBCET_OFS_WIN_CNT, 16'h0000, "width hold");
		acc(1'b1, `PBCET_OFS_WIN_SET, 16'h0000);
		tk(8'h04, 1'b0);
		repeat (2) tk(8'h00, 1'b0);
		check("zero width", {31'h0, win}, 32'h0);
		// Capture in active mode, one per reference interval
		acc(1'b1, `PBCET_OFS_CAP_CTRL, 16'h0003);
		tk(8'h04, 1'b0);
		tk(8'h00, 1'b1);
		c1 = tbc;
		rd(`PBCET_OFS_CAP_VALUE, c1, "capture");
		tk(8'h00, 1'b0);
		tk(8'h00, 1'b1);
		rd(`PBCET_OFS_CAP_VALUE, c1, "capture ignored");
		// Shadow mode lags the active copy by one reference point
		acc(1'b1, `PBCET_OFS_CAP_CTRL, 16'h0001);
		tk(8'h04, 1'b0);
		tk(8'h00, 1'b1);
		c3 = tbc;
		rd(`PBCET_OFS_CAP_VALUE, c1, "shadow old");
		tk(8'h04, 1'b0);
		rd(`PBCET_OFS_CAP_VALUE, c3, "shadow copied");
		tk(8'h00, 1'b1);
		c1 = tbc;
		acc(1'b1, `PBCET_OFS_CAP_CTRL, 16'h0003);
		rd(`PBCET_OFS_CAP_VALUE, c1, "active");
		results();
	end
endmodule : tb
bind pbcet_top pbcet_checker #(.CAP_W(CAP_W), .WIN_W(WIN_W)) pbcet_checker_i (.clk(clk),
	.arst_n(arst_n), .address(address), .read(read), .write(write), .readdata(readdata),
	.waitrequest(waitrequest), .timebase_tick(timebase_tick), .ctr_zero(ctr_zero),
	.ctr_period(ctr_period), .compare_value_a_up(compare_value_a_up), .compare_value_a_down(compare_value_a_down), .compare_value_b_up(compare_value_b_up),
	.compare_value_b_down(compare_value_b_down), .compare_a_event1_start(compare_a_event1_start),
	.compare_b_event1_start(compare_b_event1_start), .blank_window_active(blank_window_active),
	.converter_start_a_pulse(converter_start_a_pulse),
	.converter_start_b_pulse(converter_start_b_pulse), .pwm_irq_pulse(pwm_irq_pulse));
